// ==== rtl/stlsu_top.sv ====
// Single transfer load/store unit: decode, address forming, write-back, lanes.
// Assumes issue, flags and endianness come from core logic on the same clock,
// and a memory system that answers each request with a one-cycle acknowledge.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module stlsu_top (
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic                         instr_valid,
   input  wire logic [31:0]                  instr,
   input  wire logic [3:0]                   cpsr_flags,
   input  wire logic                         privileged,
   input  wire logic                         endian_select,
   output logic                              instr_ready,
   output logic                              instr_done,
   output logic                              instr_skipped,
   output stlsu_pkg::stlsu_mem_req_type      mem_out,
   input  wire logic [31:0]                  mem_rdata,
   input  wire logic                         mem_ack,
   input  wire logic [stlsu_pkg::BUS_AW-1:0] bus_addr,
   input  wire logic [31:0]                  bus_wdata,
   input  wire logic                         bus_wr,
   input  wire logic                         bus_rd,
   output logic      [31:0]                  bus_rdata
);
   import stlsu_pkg::*;

   typedef struct packed {
      stlsu_state_type   st;
      logic [31:0]       instr;
      logic              big;
      logic              priv;
      logic              carry;
      logic [31:0]       base;
      logic [31:0]       offset;
      logic [31:0]       wb_addr;
      logic [31:0]       load_data;
      stlsu_mem_req_type mem;
      logic              ready;
      logic              done;
      logic              skipped;
      logic              last_skip;
      logic              exec_en;
      logic [31:0]       last_addr;
   } stlsu_top_type;

   stlsu_top_type q_ff;
   stlsu_top_type nxt_q;
   logic [1:0]    rst_sync_ff;
   logic          rst_n;
   logic [3:0]    a_raddr;
   logic [31:0]   a_rdata;
   logic [31:0]   shifted;
   logic [31:0]   b_aux_data;
   logic          b_aux_sel;
   logic          rf_wr_en;
   logic [3:0]    rf_wr_addr;
   logic [31:0]   rf_wr_data;
   logic          bus_reg_wr;
   logic [31:0]   modified;
   logic [31:0]   eff_addr;
   logic          wb_needed;
   logic [31:0]   imm_ofs;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release is synchronised so every flip-flop leaves reset on one edge.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   stlsu_regfile #(
      .DEPTH (16),
      .WIDTH (32),
      .AW    (4)
   ) u_regfile (
      .clk        (clk),
      .rst_n      (rst_n),
      .a_raddr    (a_raddr),
      .a_rdata    (a_rdata),
      .b_raddr    (bus_addr[REG_IDX_HI:REG_IDX_LO]),
      .b_rd       (bus_rd),
      .b_aux_sel  (b_aux_sel),
      .b_aux_data (b_aux_data),
      .b_rdata    (bus_rdata),
      .wr_en      (rf_wr_en),
      .wr_addr    (rf_wr_addr),
      .wr_data    (rf_wr_data)
   );

   stlsu_shifter u_shifter (
      .opnd      (a_rdata),
      .shift_ctl (q_ff.instr[OFS_HI:SH_LO]),
      .carry_in  (q_ff.carry),
      .result    (shifted)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register read address follows the fetch sequence; data arrive one state late.
   always_comb begin
      a_raddr = q_ff.instr[RN_HI:RN_LO];
      case (q_ff.st)
         ST_BASE: a_raddr = q_ff.instr[RN_HI:RN_LO];
         ST_OFF:  a_raddr = q_ff.instr[RM_HI:RM_LO];
         ST_SRC:  a_raddr = q_ff.instr[RD_HI:RD_LO];
         default: a_raddr = q_ff.instr[RN_HI:RN_LO];
      endcase
   end

   // Software writes to the core registers only land while the unit is idle,
   // so they can never race the unit's own write-back.
   always_comb begin
      bus_reg_wr = bus_wr && (bus_addr <= REG_LAST_OFS) && (q_ff.st == ST_IDLE);
      rf_wr_en   = bus_reg_wr;
      rf_wr_addr = bus_addr[REG_IDX_HI:REG_IDX_LO];
      rf_wr_data = bus_wdata;
      if (q_ff.st == ST_WB_BASE) begin
         rf_wr_en   = 1'b1;
         rf_wr_addr = q_ff.instr[RN_HI:RN_LO];
         rf_wr_data = q_ff.wb_addr;
      end else if (q_ff.st == ST_WB_LOAD) begin
         rf_wr_en   = 1'b1;
         rf_wr_addr = q_ff.instr[RD_HI:RD_LO];
         rf_wr_data = q_ff.load_data;
      end
   end

   always_comb begin
      b_aux_sel  = (bus_addr > REG_LAST_OFS);
      b_aux_data = 32'h00000000;
      case (bus_addr)
         CTRL_OFS: b_aux_data[CTRL_EN_BIT] = q_ff.exec_en;
         STAT_OFS: begin
            b_aux_data[STAT_BUSY_BIT] = (q_ff.st != ST_IDLE);
            b_aux_data[STAT_SKIP_BIT] = q_ff.last_skip;
         end
         LADDR_OFS: b_aux_data = q_ff.last_addr;
         default: b_aux_data = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address arithmetic on the captured base and offset.
   always_comb begin
      imm_ofs   = {20'h00000, q_ff.instr[IMM_W-1:0]};
      modified  = q_ff.instr[UP_BIT] ? q_ff.base + q_ff.offset
                                     : q_ff.base - q_ff.offset;
      eff_addr  = q_ff.instr[PRE_BIT] ? modified : q_ff.base;
      wb_needed = ~q_ff.instr[PRE_BIT] | q_ff.instr[WB_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_q         = q_ff;
      nxt_q.done    = 1'b0;
      nxt_q.skipped = 1'b0;
      if (bus_wr && (bus_addr == CTRL_OFS)) begin
         nxt_q.exec_en = bus_wdata[CTRL_EN_BIT];
      end
      case (q_ff.st)
         ST_IDLE: begin
            if (instr_valid && q_ff.ready) begin
               nxt_q.instr = instr;
               nxt_q.big   = endian_select;
               nxt_q.priv  = privileged;
               nxt_q.carry = cpsr_flags[FLAG_C];
               if (stlsu_cond_pass(instr[COND_HI:COND_LO], cpsr_flags)) begin
                  nxt_q.st        = ST_BASE;
                  nxt_q.last_skip = 1'b0;
               end else begin
                  nxt_q.skipped   = 1'b1;
                  nxt_q.done      = 1'b1;
                  nxt_q.last_skip = 1'b1;
               end
            end
         end
         ST_BASE: nxt_q.st = ST_OFF;
         ST_OFF: begin
            nxt_q.base = a_rdata;
            nxt_q.st   = ST_SRC;
         end
         ST_SRC: begin
            nxt_q.offset = q_ff.instr[IMM_BIT] ? shifted : imm_ofs;
            nxt_q.st     = ST_ADDR;
         end
         ST_ADDR: begin
            nxt_q.wb_addr      = modified;
            nxt_q.mem.req      = 1'b1;
            nxt_q.mem.we       = ~q_ff.instr[LOAD_BIT];
            nxt_q.mem.byte_sel = q_ff.instr[BYTE_BIT];
            nxt_q.mem.user     = q_ff.priv & ~q_ff.instr[PRE_BIT]
                                 & q_ff.instr[WB_BIT];
            nxt_q.mem.addr     = eff_addr;
            // Lane enables are the memory system's job; the unit drives every lane.
            nxt_q.mem.wdata    = q_ff.instr[BYTE_BIT] ? {4{a_rdata[LANE_W-1:0]}}
                                                      : a_rdata;
            nxt_q.st           = ST_MEM;
         end
         ST_MEM: begin
            if (mem_ack) begin
               nxt_q.mem.req   = 1'b0;
               nxt_q.mem.user  = 1'b0;
               nxt_q.last_addr = q_ff.mem.addr;
               nxt_q.load_data = stlsu_load_align(mem_rdata, q_ff.mem.addr[1:0],
                                                  q_ff.instr[BYTE_BIT],
                                                  q_ff.big);
               if (wb_needed) begin
                  nxt_q.st = ST_WB_BASE;
               end else if (q_ff.instr[LOAD_BIT]) begin
                  nxt_q.st = ST_WB_LOAD;
               end else begin
                  nxt_q.st   = ST_IDLE;
                  nxt_q.done = 1'b1;
               end
            end
         end
         // Base goes first so that a load into the base register keeps the loaded word.
         ST_WB_BASE: begin
            if (q_ff.instr[LOAD_BIT]) begin
               nxt_q.st = ST_WB_LOAD;
            end else begin
               nxt_q.st   = ST_IDLE;
               nxt_q.done = 1'b1;
            end
         end
         ST_WB_LOAD: begin
            nxt_q.st   = ST_IDLE;
            nxt_q.done = 1'b1;
         end
         default: nxt_q.st = ST_IDLE;
      endcase
      nxt_q.ready = (nxt_q.st == ST_IDLE) && nxt_q.exec_en && !nxt_q.done;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff         <= '0;
         q_ff.st      <= ST_IDLE;
         q_ff.exec_en <= CTRL_EN_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign instr_ready   = q_ff.ready;
   assign instr_done    = q_ff.done;
   assign instr_skipped = q_ff.skipped;
   assign mem_out       = q_ff.mem;
endmodule : stlsu_top

// ==== pkg/stlsu_pkg.sv ====
// Constants, types and helper functions of the single transfer load/store unit.
// Assumes a 32-bit core register file of sixteen words and a 32-bit data bus.
// Operation
// - Transfer runs only when condition field [31:28] passes; else no effect.
// - Base register from [19:16]; source or destination register from [15:12].
// - Bit 20 one loads from memory, zero stores to memory.
// - Pre-indexed: write modified address to base only when bit 21 set.
// - Bit 22 one moves a byte, zero moves a 32-bit word.
// - Bit 23 one adds offset to base, zero subtracts it.
// - Bit 24 one applies offset before the transfer, zero after it.
// - Post-indexed transfers always write the modified address back.
// - Post-indexed with write-back from privileged code marks access non-privileged.
// - Bit 25 zero: bits [11:0] are an unsigned twelve-bit immediate offset.
// - Register offset from [3:0], immediate shift control [11:4]; no register shifts.
// - Little-endian byte load takes lane 7:0 at offset zero, upward after.
// - Byte load zero-extends the selected byte into the destination.
// - Byte store repeats source bits 7:0 four times on all lanes.
// - Little-endian misaligned word load rotates addressed byte into bits 7:0.
// - Word store presents register unrotated, bit 31 on line 31.
// - Lane mapping follows the endianness control input.
////////////////////////////////////////////////////////////////////////////////
package stlsu_pkg;
   localparam int COND_HI = 31;
   localparam int COND_LO = 28;
   localparam int IMM_BIT = 25;
   localparam int PRE_BIT = 24;
   localparam int UP_BIT  = 23;
   localparam int BYTE_BIT = 22;
   localparam int WB_BIT  = 21;
   localparam int LOAD_BIT = 20;
   localparam int RN_HI   = 19;
   localparam int RN_LO   = 16;
   localparam int RD_HI   = 15;
   localparam int RD_LO   = 12;
   localparam int OFS_HI  = 11;
   localparam int SH_LO   = 4;
   localparam int RM_HI   = 3;
   localparam int RM_LO   = 0;
   localparam int FLAG_N  = 3;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_C  = 1;
   localparam int FLAG_V  = 0;
   localparam int IMM_W   = 12;
   localparam int LANE_W  = 8;
   localparam int BUS_AW  = 8;
   localparam int REG_IDX_HI = 5;
   localparam int REG_IDX_LO = 2;
   localparam logic [BUS_AW-1:0] REG_LAST_OFS = 8'h3c;
   localparam logic [BUS_AW-1:0] CTRL_OFS     = 8'h40;
   localparam logic [BUS_AW-1:0] STAT_OFS     = 8'h44;
   localparam logic [BUS_AW-1:0] LADDR_OFS    = 8'h48;
   localparam int CTRL_EN_BIT   = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_SKIP_BIT = 1;
   localparam logic [1:0] SH_LSL = 2'h0;
   localparam logic [1:0] SH_LSR = 2'h1;
   localparam logic [1:0] SH_ASR = 2'h2;
   localparam logic [1:0] SH_ROR = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_BASE, ST_OFF, ST_SRC, ST_ADDR, ST_MEM, ST_WB_BASE, ST_WB_LOAD
   } stlsu_state_type;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        byte_sel;
      logic        user;
      logic [31:0] addr;
      logic [31:0] wdata;
   } stlsu_mem_req_type;

   // Low condition bit inverts the sense of the pair; code 4'hf thus never passes.
   function automatic logic stlsu_cond_pass(input logic [3:0] cond, input logic [3:0] f);
      logic base;
      base = 1'b1;
      case (cond[3:1])
         3'h0: base = f[FLAG_Z];
         3'h1: base = f[FLAG_C];
         3'h2: base = f[FLAG_N];
         3'h3: base = f[FLAG_V];
         3'h4: base = f[FLAG_C] & ~f[FLAG_Z];
         3'h5: base = (f[FLAG_N] == f[FLAG_V]);
         3'h6: base = ~f[FLAG_Z] & (f[FLAG_N] == f[FLAG_V]);
         default: base = 1'b1;
      endcase
      return base ^ cond[0];
   endfunction : stlsu_cond_pass

   function automatic logic [31:0] stlsu_load_align(input logic [31:0] d,
                                                    input logic [1:0]  a,
                                                    input logic        byte_sel,
                                                    input logic        big);
      logic [1:0]  lane;
      logic [4:0]  sh;
      logic [63:0] rr;
      logic [63:0] rl;
      logic [31:0] bsel;
      lane = big ? ~a : a;
      sh   = {a, 3'h0};
      rr   = {d, d} >> sh;
      rl   = {d, d} << sh;
      bsel = d >> {lane, 3'h0};
      if (byte_sel) begin
         return {24'h000000, bsel[LANE_W-1:0]};
      end
      return big ? rl[63:32] : rr[31:0];
   endfunction : stlsu_load_align
endpackage : stlsu_pkg

// ==== rtl/stlsu_shifter.sv ====
// Immediate-amount barrel shifter for the register offset.
// Assumes an eight-bit shift control: amount [7:3], type [2:1], bit 0 ignored.
`timescale 1ns/1ps
module stlsu_shifter (
   input  wire logic [31:0] opnd,
   input  wire logic [7:0]  shift_ctl,
   input  wire logic        carry_in,
   output logic [31:0]      result
);
   import stlsu_pkg::*;

   logic [4:0]  amt;
   logic [63:0] dbl;

   ////////////////////////////////////////////////////////////////////////////
   // A zero amount means 32 for the right shifts and one-bit extended rotate.
   always_comb begin
      amt    = shift_ctl[7:3];
      dbl    = {opnd, opnd} >> amt;
      result = opnd;
      case (shift_ctl[2:1])
         SH_LSL: result = opnd << amt;
         SH_LSR: result = (amt == 5'h00) ? 32'h00000000 : opnd >> amt;
         SH_ASR: result = (amt == 5'h00) ? {32{opnd[31]}} : 32'($signed(opnd) >>> amt);
         SH_ROR: result = (amt == 5'h00) ? {carry_in, opnd[31:1]} : dbl[31:0];
         default: result = opnd;
      endcase
   end
endmodule : stlsu_shifter

// ==== rtl/stlsu_regfile.sv ====
// Core register file: one write port, one core read port, one software read port.
// Assumes synchronous use; read data appear one cycle after the address.
`timescale 1ns/1ps
module stlsu_regfile #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 32,
   parameter int AW    = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [AW-1:0]    a_raddr,
   output logic      [WIDTH-1:0] a_rdata,
   input  wire logic [AW-1:0]    b_raddr,
   input  wire logic             b_rd,
   input  wire logic             b_aux_sel,
   input  wire logic [WIDTH-1:0] b_aux_data,
   output logic      [WIDTH-1:0] b_rdata,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data
);
   typedef struct packed {
      logic [WIDTH-1:0] a;
      logic [WIDTH-1:0] b;
   } stlsu_rf_type;

   logic [WIDTH-1:0] mem [DEPTH];
   stlsu_rf_type     q_ff;
   stlsu_rf_type     nxt_q;

   ////////////////////////////////////////////////////////////////////////////
   // The software port reads zero except in the cycle after a read strobe.
   always_comb begin
      nxt_q   = q_ff;
      nxt_q.a = mem[a_raddr];
      nxt_q.b = '0;
      if (b_rd) begin
         nxt_q.b = b_aux_sel ? b_aux_data : mem[b_raddr];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign a_rdata = q_ff.a;
   assign b_rdata = q_ff.b;
endmodule : stlsu_regfile

// ==== testbench/stlsu_monitor.sv ====
// Checker of the load/store unit: memory request fields against the accepted word.
// Assumes it is bound to stlsu_top and sees only that module's ports.
`timescale 1ns/1ps
module stlsu_monitor (
   input wire logic                         clk,
   input wire logic                         arst_n,
   input wire logic                         instr_valid,
   input wire logic [31:0]                  instr,
   input wire logic                         privileged,
   input wire logic                         instr_ready,
   input wire logic                         instr_done,
   input wire logic                         instr_skipped,
   input wire stlsu_pkg::stlsu_mem_req_type mem_out,
   input wire logic                         mem_ack
);
   import stlsu_pkg::*;
   logic [31:0] inst_ff;
   logic        priv_ff;
   // Fields are judged against the word taken at issue, since the live input may move on.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inst_ff <= 32'h0;
         priv_ff <= 1'b0;
      end else if (instr_valid && instr_ready) begin
         inst_ff <= instr;
         priv_ff <= privileged;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////
   property p_skip_nv;
      instr_valid && instr_ready && instr[COND_HI:COND_LO] == 4'hf |=> instr_done && instr_skipped;
   endproperty
   a_skip_nv: assert property (p_skip_nv) else $error("failing condition not skipped");
   property p_skip_pair;
      instr_skipped |-> instr_done && !mem_out.req;
   endproperty
   a_skip_pair: assert property (p_skip_pair) else $error("skip without done or with request");
   property p_exec_req;
      instr_valid && instr_ready && instr[COND_HI:COND_LO] == 4'he |-> ##5 mem_out.req;
   endproperty
   a_exec_req: assert property (p_exec_req) else $error("always condition gave no request");
   property p_dir;
      mem_out.req |-> mem_out.we == !inst_ff[LOAD_BIT];
   endproperty
   a_dir: assert property (p_dir) else $error("request direction wrong");
   property p_size;
      mem_out.req |-> mem_out.byte_sel == inst_ff[BYTE_BIT];
   endproperty
   a_size: assert property (p_size) else $error("request size wrong");
   property p_rep;
      mem_out.req && mem_out.we && mem_out.byte_sel |-> mem_out.wdata == {4{mem_out.wdata[7:0]}};
   endproperty
   a_rep: assert property (p_rep) else $error("byte store lanes differ");
   property p_user;
      mem_out.req |-> mem_out.user == (!inst_ff[PRE_BIT] && inst_ff[WB_BIT] && priv_ff);
   endproperty
   a_user: assert property (p_user) else $error("access privilege mark wrong");
   property p_finish;
      mem_out.req && mem_ack |=> !mem_out.req ##[0:2] instr_done;
   endproperty
   a_finish: assert property (p_finish) else $error("no completion after acknowledge");
endmodule : stlsu_monitor
bind stlsu_top stlsu_monitor u_monitor (
   .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
   .privileged(privileged), .instr_ready(instr_ready), .instr_done(instr_done),
   .instr_skipped(instr_skipped), .mem_out(mem_out), .mem_ack(mem_ack)
);

// ==== testbench/stlsu_mem_model.sv ====
// Memory system model: sixteen words, acknowledge after a bench-set delay.
// Assumes one request at a time; byte stores write only the lane of the addressed byte.
`timescale 1ns/1ps
module stlsu_mem_model (
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire stlsu_pkg::stlsu_mem_req_type mem_out,
   input  wire logic                         endian_select,
   input  wire logic [1:0]                   ack_delay,
   output logic      [31:0]                  mem_rdata,
   output logic                              mem_ack,
   output stlsu_pkg::stlsu_mem_req_type      last_req
);
   import stlsu_pkg::*;
   logic [31:0] mem [16];
   logic [1:0]  wait_ff;
   logic [4:0]  lane_sh;
   assign lane_sh = {endian_select ? ~mem_out.addr[1:0] : mem_out.addr[1:0], 3'h0};
   initial for (int i = 0; i < 16; i++) mem[i] = 32'h1f2e3d4c * (i + 1);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack   <= 1'b0;
         wait_ff   <= 2'h0;
         mem_rdata <= 32'h0;
         last_req  <= '0;
      end else if (mem_ack) begin
         mem_ack   <= 1'b0;
         wait_ff   <= 2'h0;
         // Data are not held past the acknowledge, so a late sample sees garbage.
         mem_rdata <= ~mem_rdata;
      end else if (mem_out.req && wait_ff != ack_delay) begin
         wait_ff <= wait_ff + 2'h1;
      end else if (mem_out.req) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem[mem_out.addr[5:2]];
         last_req  <= mem_out;
         if (mem_out.we && mem_out.byte_sel) begin
            mem[mem_out.addr[5:2]][lane_sh +: 8] <= mem_out.wdata[lane_sh +: 8];
         end else if (mem_out.we) begin
            mem[mem_out.addr[5:2]] <= mem_out.wdata;
         end
      end
   end
endmodule : stlsu_mem_model

// ==== testbench/stlsu_tb_top.sv ====
// Self-checking bench of the load/store unit: random transfers against a bench model.
// Assumes the memory model of stlsu_mem_model and the bound checker.
`timescale 1ns/1ps
module stlsu_tb_top;
   import stlsu_pkg::*;
   logic              clk = 1'b0;
   logic              arst_n = 1'b0;
   logic              instr_valid = 1'b0;
   logic [31:0]       instr = 32'h0;
   logic [3:0]        cpsr_flags = 4'h0;
   logic              privileged = 1'b0;
   logic              endian_select = 1'b0;
   logic              instr_ready, instr_done, instr_skipped, mem_ack;
   stlsu_mem_req_type mem_out, last_req;
   logic [31:0]       mem_rdata, bus_rdata;
   logic [1:0]        ack_delay = 2'h0;
   logic [BUS_AW-1:0] bus_addr = 8'h0;
   logic [31:0]       bus_wdata = 32'h0;
   logic              bus_wr = 1'b0;
   logic              bus_rd = 1'b0;
   logic [31:0]       lfsr = 32'h000140d8;
   int                err_count = 0;
   int                n_tests = 0;
   always #5 clk = ~clk;
   stlsu_top dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
      .cpsr_flags(cpsr_flags), .privileged(privileged), .endian_select(endian_select),
      .instr_ready(instr_ready), .instr_done(instr_done), .instr_skipped(instr_skipped),
      .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
   stlsu_mem_model u_mem (.clk(clk), .arst_n(arst_n), .mem_out(mem_out),
      .endian_select(endian_select), .ack_delay(ack_delay), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .last_req(last_req));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
      return lfsr;
   endfunction : rnd
   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
      logic r;
      case (c[3:1])
         3'h0: r = f[2];
         3'h1: r = f[1];
         3'h2: r = f[3];
         3'h3: r = f[0];
         3'h4: r = f[1] & ~f[2];
         3'h5: r = f[3] == f[0];
         3'h6: r = ~f[2] & (f[3] == f[0]);
         default: r = 1'b1;
      endcase
      return (c == 4'hf) ? 1'b0 : r ^ c[0];
   endfunction : cond_ok
   function automatic logic [31:0] sh_exp(input logic [31:0] v, input logic [4:0] n,
      input logic [1:0] t, input logic c);
      logic [63:0] dd;
      dd = {v, v} >> n;
      if (t == 2'h0) return v << n;
      if (n == 5'h0) return (t == 2'h1) ? 32'h0 : (t == 2'h2) ? {32{v[31]}} : {c, v[31:1]};
      return (t == 2'h1) ? v >> n : (t == 2'h2) ? 32'($signed(v) >>> n) : dd[31:0];
   endfunction : sh_exp
   function automatic logic [31:0] ld_exp(input logic [31:0] d, input logic [1:0] a,
                                          input logic by, input logic big);
      logic [63:0] rr;
      logic [63:0] rl;
      rr = {d, d} >> {a, 3'h0};
      rl = {d, d} << {a, 3'h0};
      if (by) return {24'h0, d[{big ? ~a : a, 3'h0} +: 8]};
      return big ? rl[63:32] : rr[31:0];
   endfunction : ld_exp
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (exp !== got) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask : check
   task automatic bus_write(input logic [BUS_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask : bus_write
   task automatic bus_read(input logic [BUS_AW-1:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask : bus_read
   task automatic stop_test();
      if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input int i);
      logic [31:0] w, e, base, offv, rdv, ofs, nb, ad, mw, r;
      logic [3:0]  cnd, rn, rd;
      logic        im, p, u, b, wb, ld, pass;
      int          k;
      w = rnd();
      e = rnd();
      base = rnd();
      offv = rnd();
      rdv = rnd();
      // The first sixteen transfers walk every condition code.
      cnd = (i < 16) ? i[3:0] : w[31:28];
      {im, p, u, b, wb, ld} = w[25:20];
      rn = {2'h0, w[13:12]};
      rd = {2'h2, w[15:14]};
      bus_write({2'h0, rn, 2'h0}, base);
      bus_write(8'h14, offv);
      bus_write({2'h0, rd, 2'h0}, rdv);
      ofs  = im ? sh_exp(offv, e[11:7], e[6:5], w[9]) : {20'h0, e[19:8]};
      nb   = u ? base + ofs : base - ofs;
      ad   = p ? nb : base;
      mw   = u_mem.mem[ad[5:2]];
      pass = cond_ok(cnd, w[11:8]);
      #1;
      for (k = 0; k < 20 && instr_ready !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      instr_valid   <= 1'b1;
      instr         <= {cnd, 2'h1, im, p, u, b, wb, ld, rn, rd, im ? {e[11:4], 4'h5} : e[19:8]};
      cpsr_flags    <= w[11:8];
      privileged    <= e[22];
      endian_select <= e[23];
      ack_delay     <= e[21:20];
      @(posedge clk);
      instr_valid <= 1'b0;
      for (k = 0; k < 40; k++) begin
         #1;
         if (instr_done === 1'b1) break;
         @(posedge clk);
      end
      check("done", 32'h1, {31'h0, instr_done});
      check("skipped", {31'h0, !pass}, {31'h0, instr_skipped});
      if (pass) begin
         check("address", ad, last_req.addr);
         check("direction", {31'h0, !ld}, {31'h0, last_req.we});
         check("size", {31'h0, b}, {31'h0, last_req.byte_sel});
         check("user", {31'h0, !p && wb && e[22]}, {31'h0, last_req.user});
         if (!ld) check("store data", b ? {4{rdv[7:0]}} : rdv, last_req.wdata);
      end
      r = mw;
      r[{e[23] ? ~ad[1:0] : ad[1:0], 3'h0} +: 8] = rdv[7:0];
      check("memory", (pass && !ld) ? (b ? r : rdv) : mw, u_mem.mem[ad[5:2]]);
      bus_read({2'h0, rn, 2'h0}, r);
      check("base", (pass && (!p || wb)) ? nb : base, r);
      bus_read({2'h0, rd, 2'h0}, r);
      check("data", (pass && ld) ? ld_exp(mw, ad[1:0], b, e[23]) : rdv, r);
   endtask : xfer
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      bus_read(CTRL_OFS, r);
      check("ctrl reset", 32'h1, r);
      bus_read(STAT_OFS, r);
      check("status reset", 32'h0, r);
      bus_read(LADDR_OFS, r);
      check("last address reset", 32'h0, r);
      bus_read(8'h80, r);
      check("unmapped read", 32'h0, r);
      for (int i = 0; i < 80; i++) xfer(i);
      stop_test();
   end
   initial begin
      #500000;
      err_count++;
      stop_test();
   end
endmodule : stlsu_tb_top
